// ### rtl/sdsi_pkg.sv
// Shared constants of the step/direction input and diagnostic status block
package sdsi_pkg;
   // Quiet cycles on the step input before standstill is flagged
   localparam int STANDSTILL_FLAG_CYCLES = 1048576;
   // Width of the status response word
   localparam int RESP_W = 20;
   // Response bit positions
   localparam int RB_STALL = 0;
   localparam int RB_OT = 1;
   localparam int RB_OVERTEMP_WARNING_FLAG = 2;
   localparam int RB_SHORT_FLAG_COIL_A = 3;
   localparam int RB_SHORT_FLAG_COIL_B = 4;
   localparam int RB_OLA = 5;
   localparam int RB_OLB = 6;
   localparam int RB_STANDSTILL_FLAG = 7;
   localparam int RB_SPARE_LO = 8;
   localparam int RB_UPPER_LO = 10;
   // Read-select codes for the upper response field
   localparam logic [1:0] RSEL_MICROSTEP_POSITION = 2'h0;
   localparam logic [1:0] RSEL_STALL = 2'h1;
   localparam logic [1:0] RSEL_LOAD = 2'h2;
   localparam logic [1:0] RSEL_DIAG = 2'h3;
   // Short-event count that latches the bridge off
   localparam logic [1:0] SHORT_LIMIT = 2'h3;
   // Open-load clear threshold is max current shifted right by this
   localparam int OL_CLEAR_SHIFT = 4;
   // Reset values
   localparam logic [9:0] MICROSTEP_POSITION_RST = 10'h000;
   localparam logic [19:0] RESP_RST = 20'h00000;
   localparam logic [1:0] SPARE_ZERO = 2'h0;
   localparam logic [1:0] SPARE_ONE = 2'h3;
endpackage : sdsi_pkg

// ### rtl/sdsi_step_if.sv
// Carrier between step input stage and status logic
`timescale 1ns/1ps
`default_nettype none
interface sdsi_step_if;
   logic step_pulse; // One-cycle pulse per active step edge
   logic step_dir;   // Synchronised direction, valid with the pulse
   logic standstill; // Standstill flag
   modport src (output step_pulse, output step_dir, output standstill);
   modport snk (input step_pulse, input step_dir, input standstill);
endinterface : sdsi_step_if
`default_nettype wire

// ### rtl/sdsi_step_in.sv
// Step/direction synchroniser, edge qualifier and standstill timer
`timescale 1ns/1ps
`default_nettype none
module sdsi_step_in #(
   parameter int STANDSTILL_FLAG_CYCLES = sdsi_pkg::STANDSTILL_FLAG_CYCLES,
   parameter int CNT_W = $clog2(STANDSTILL_FLAG_CYCLES + 1)
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic step_raw,
   input wire logic dir_raw,
   input wire logic double_edge_bit,
   sdsi_step_if.src ifc
);
   localparam logic [CNT_W-1:0] CNT_END = CNT_W'(STANDSTILL_FLAG_CYCLES);

   // All state of the input stage
   typedef struct packed {
      logic step_s1;   // First sync stage, read only by second
      logic step_s2;   // Second sync stage
      logic step_prev; // Previous synchronised level
      logic dir_s1;    // First sync stage of direction
      logic dir_s2;    // Second sync stage of direction
      logic [CNT_W-1:0] quiet; // Cycles since last active edge
      logic standstill_flag;      // Standstill flag
      logic pulse;     // Active edge pulse
      logic dir;       // Direction captured with the pulse
   } sdsi_in_t;

   sdsi_in_t s_q;
   sdsi_in_t s_d;
   logic active; // Active edge on the synchronised step

   // Next state of the input stage
   always_comb
   begin
      s_d = s_q;
      s_d.step_s1 = step_raw;
      s_d.step_s2 = s_q.step_s1;
      s_d.step_prev = s_q.step_s2;
      s_d.dir_s1 = dir_raw;
      s_d.dir_s2 = s_q.dir_s1;
      // Both edges or rising only
      if (double_edge_bit)
      begin
         active = s_q.step_s2 ^ s_q.step_prev;
      end
      else
      begin
         active = s_q.step_s2 & ~s_q.step_prev;
      end
      s_d.pulse = active;
      s_d.dir = s_q.dir_s2;
      // Quiet timer restarts on an active edge, saturates at the end
      if (active)
      begin
         s_d.quiet = '0;
         s_d.standstill_flag = 1'b0;
      end
      else if (s_q.quiet != CNT_END)
      begin
         s_d.quiet = s_q.quiet + 1'b1;
         s_d.standstill_flag = (s_q.quiet + 1'b1) == CNT_END;
      end
   end

   // State register, frozen while the clock enable is low
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q <= '0;
      end
      else if (clk_en)
      begin
         s_q <= s_d;
      end
   end

   assign ifc.step_pulse = s_q.pulse;
   assign ifc.step_dir = s_q.dir;
   assign ifc.standstill = s_q.standstill_flag;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_rise_pulse: assert property (clk_en && s_q.step_s2 && !s_q.step_prev |=> s_q.pulse)
      else $error("rising step edge gave no pulse");
   a_fall_single: assert property (clk_en && !double_edge_bit && !s_q.step_s2 && s_q.step_prev
      |=> !s_q.pulse)
      else $error("falling edge counted in single-edge mode");
   a_standstill_flag_clear: assert property (clk_en && active |=> !s_q.standstill_flag)
      else $error("standstill not cleared by active edge");
   a_standstill_flag_set: assert property (clk_en && !active && s_q.quiet == CNT_END - 1'b1
      |=> s_q.standstill_flag)
      else $error("standstill not set after quiet period");
   c_standstill_flag: cover property (s_q.standstill_flag);
endmodule : sdsi_step_in
`default_nettype wire

// ### rtl/sdsi_top.sv
// Step/direction input logic and low-order diagnostic status of a stepper driver
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Standstill after 2^20 cycles without active edge
// - Open load if no chop during polarity interval
// - Open load clears only above max/16 current
// - Open load flag never shuts anything down
// - Per-coil short flag follows short condition
// - Short event increments counter, suspends chopper
// - Short counter decrements on polarity change
// - Counter at 3 latches bridge off
// - Disable or zero off-time clears shutdown
// - Warning flag follows warning threshold
// - Shutdown flag shows overtemperature shutdown
// - Stall flag drives stall test pin high
// - Double-edge bit makes both edges active
// - Step and direction synchronised before use
// - Each config write returns 20-bit status
// - Next active edge clears standstill
// - Microstep counter moves by step size
module sdsi_top #(
   parameter int STANDSTILL_FLAG_CYCLES = sdsi_pkg::STANDSTILL_FLAG_CYCLES,
   parameter int CUR_W = 8
) (
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire logic CLK_EN,
   input wire logic STEP,
   input wire logic DIR,
   input wire logic DOUBLE_EDGE_BIT,
   input wire logic [3:0] MICROSTEP_RES,
   input wire logic [1:0] READ_SELECT,
   input wire logic DRIVER_ENABLE_N,
   input wire logic [3:0] CHOPPER_OFF_TIME,
   input wire logic CONFIG_WRITE,
   input wire logic [9:0] UPPER_FIELD,
   input wire logic POLARITY_A,
   input wire logic POLARITY_B,
   input wire logic CHOP_EVENT_A,
   input wire logic CHOP_EVENT_B,
   input wire logic [CUR_W-1:0] CURRENT_A,
   input wire logic [CUR_W-1:0] CURRENT_B,
   input wire logic [CUR_W-1:0] CURRENT_MAX,
   input wire logic SHORT_DET_A,
   input wire logic SHORT_DET_B,
   input wire logic OVERTEMP_WARN_IN,
   input wire logic OVERTEMP_SHUT_IN,
   input wire logic STALL_DET_IN,
   output logic [19:0] DRIVER_STATUS_RESPONSE,
   output logic RESPONSE_VALID,
   output logic [9:0] MICROSTEP_POSITION,
   output logic STANDSTILL_FLAG,
   output logic BRIDGE_OFF,
   output logic CHOP_SUSPEND,
   output logic STALL_TEST_OUTPUT
);
   // All state of the status logic except the standstill output copy
   typedef struct packed {
      logic [19:0] resp;      // Response word loaded for shifting
      logic resp_vld;         // Response load pulse
      logic [9:0] microstep_position;      // Microstep position
      logic pol_a;            // Previous coil A polarity
      logic pol_b;            // Previous coil B polarity
      logic chop_a;           // Chop seen in current coil A interval
      logic chop_b;           // Chop seen in current coil B interval
      logic ol_a;             // Open load coil A
      logic ol_b;             // Open load coil B
      logic sh_a;             // Short flag coil A
      logic sh_b;             // Short flag coil B
      logic [1:0] sh_cnt;     // Short-event counter
      logic off;              // Latched bridge shutdown
      logic suspend;          // Chopper suspend pulse
      logic overtemp_warning_flag;             // Overtemperature warning
      logic ot;               // Overtemperature shutdown
      logic stall;            // Stall flag
   } sdsi_st_t;

   sdsi_st_t s_q;
   sdsi_st_t s_d;
   sdsi_step_if step_ifc ();
   logic chg_a;     // Coil A polarity changed
   logic chg_b;     // Coil B polarity changed
   logic sh_evt;    // New short event on either coil
   logic drv_off;   // Driver disabled
   logic [2:0] cnt_sum; // Counter arithmetic with headroom
   logic [7:0] low_bits; // Live low-order status

   // Step input stage
   sdsi_step_in #(
      .STANDSTILL_FLAG_CYCLES(STANDSTILL_FLAG_CYCLES)
   ) u_step_in (
      .clk(CLOCK),
      .rst_n(RSTN),
      .clk_en(CLK_EN),
      .step_raw(STEP),
      .dir_raw(DIR),
      .double_edge_bit(DOUBLE_EDGE_BIT),
      .ifc(step_ifc.src)
   );

   // Step size from resolution code
   function automatic logic [9:0] step_size(input logic [3:0] res);
      step_size = (res > 4'h8) ? 10'h100 : 10'(10'h001 << res);
   endfunction : step_size

   // Next open-load flag of one coil
   function automatic logic ol_next(input logic flag, input logic chg, input logic seen,
                                    input logic [CUR_W-1:0] cur, input logic [CUR_W-1:0] cmax);
      if (chg && !seen)
      begin
         ol_next = 1'b1;
      end
      else if (cur > (cmax >> sdsi_pkg::OL_CLEAR_SHIFT))
      begin
         ol_next = 1'b0;
      end
      else
      begin
         ol_next = flag;
      end
   endfunction : ol_next

   // Next state of the status logic
   always_comb
   begin
      s_d = s_q;
      chg_a = POLARITY_A ^ s_q.pol_a;
      chg_b = POLARITY_B ^ s_q.pol_b;
      // Microstep counter follows active edges
      if (step_ifc.step_pulse)
      begin
         if (step_ifc.step_dir)
         begin
            s_d.microstep_position = s_q.microstep_position - step_size(MICROSTEP_RES);
         end
         else
         begin
            s_d.microstep_position = s_q.microstep_position + step_size(MICROSTEP_RES);
         end
      end
      // Open load tracking per polarity interval, status only
      s_d.pol_a = POLARITY_A;
      s_d.pol_b = POLARITY_B;
      s_d.ol_a = ol_next(s_q.ol_a, chg_a, s_q.chop_a, CURRENT_A, CURRENT_MAX);
      s_d.ol_b = ol_next(s_q.ol_b, chg_b, s_q.chop_b, CURRENT_B, CURRENT_MAX);
      s_d.chop_a = chg_a ? CHOP_EVENT_A : (s_q.chop_a | CHOP_EVENT_A);
      s_d.chop_b = chg_b ? CHOP_EVENT_B : (s_q.chop_b | CHOP_EVENT_B);
      // Short flags follow the condition
      s_d.sh_a = SHORT_DET_A;
      s_d.sh_b = SHORT_DET_B;
      sh_evt = (SHORT_DET_A & ~s_q.sh_a) | (SHORT_DET_B & ~s_q.sh_b);
      drv_off = DRIVER_ENABLE_N || (CHOPPER_OFF_TIME == 4'h0);
      cnt_sum = {1'b0, s_q.sh_cnt} + {2'h0, sh_evt};
      if (drv_off)
      begin
         s_d.sh_cnt = 2'h0;
         s_d.off = 1'b0;
         s_d.suspend = 1'b0;
      end
      else
      begin
         if ((chg_a || chg_b) && cnt_sum != 3'h0)
         begin
            cnt_sum = cnt_sum - 3'h1;
         end
         s_d.sh_cnt = (cnt_sum > 3'(sdsi_pkg::SHORT_LIMIT)) ? sdsi_pkg::SHORT_LIMIT
                                                            : cnt_sum[1:0];
         s_d.off = s_q.off || (s_d.sh_cnt == sdsi_pkg::SHORT_LIMIT);
         s_d.suspend = sh_evt;
      end
      // Temperature and stall flags
      s_d.overtemp_warning_flag = OVERTEMP_WARN_IN;
      s_d.ot = OVERTEMP_SHUT_IN;
      s_d.stall = STALL_DET_IN;
      // Live flags for the response
      low_bits = '0;
      low_bits[sdsi_pkg::RB_STALL] = s_q.stall;
      low_bits[sdsi_pkg::RB_OT] = s_q.ot;
      low_bits[sdsi_pkg::RB_OVERTEMP_WARNING_FLAG] = s_q.overtemp_warning_flag;
      low_bits[sdsi_pkg::RB_SHORT_FLAG_COIL_A] = s_q.sh_a;
      low_bits[sdsi_pkg::RB_SHORT_FLAG_COIL_B] = s_q.sh_b;
      low_bits[sdsi_pkg::RB_OLA] = s_q.ol_a;
      low_bits[sdsi_pkg::RB_OLB] = s_q.ol_b;
      low_bits[sdsi_pkg::RB_STANDSTILL_FLAG] = step_ifc.standstill;
      // Response loaded on every configuration write
      s_d.resp_vld = CONFIG_WRITE;
      if (CONFIG_WRITE)
      begin
         s_d.resp[7:0] = low_bits;
         case (READ_SELECT)
            sdsi_pkg::RSEL_MICROSTEP_POSITION:
            begin
               s_d.resp[19:8] = {s_q.microstep_position, sdsi_pkg::SPARE_ZERO};
            end
            sdsi_pkg::RSEL_DIAG:
            begin
               s_d.resp[19:8] = {UPPER_FIELD, sdsi_pkg::SPARE_ONE};
            end
            default:
            begin
               s_d.resp[19:8] = {UPPER_FIELD, sdsi_pkg::SPARE_ZERO};
            end
         endcase
      end
   end

   // State register, frozen while the clock enable is low
   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         s_q <= '0;
         s_q.microstep_position <= sdsi_pkg::MICROSTEP_POSITION_RST;
         s_q.resp <= sdsi_pkg::RESP_RST;
      end
      else if (CLK_EN)
      begin
         s_q <= s_d;
      end
   end

   // Standstill output copy, straight from a flop
   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         STANDSTILL_FLAG <= 1'b0;
      end
      else if (CLK_EN)
      begin
         STANDSTILL_FLAG <= step_ifc.standstill;
      end
   end

   assign DRIVER_STATUS_RESPONSE = s_q.resp;
   assign RESPONSE_VALID = s_q.resp_vld;
   assign MICROSTEP_POSITION = s_q.microstep_position;
   assign BRIDGE_OFF = s_q.off;
   assign CHOP_SUSPEND = s_q.suspend;
   assign STALL_TEST_OUTPUT = s_q.stall;

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RSTN);

   a_microstep_position_up: assert property (CLK_EN && step_ifc.step_pulse && !step_ifc.step_dir
      |=> MICROSTEP_POSITION == 10'($past(MICROSTEP_POSITION) + step_size($past(MICROSTEP_RES))))
      else $error("microstep did not advance by step size");
   a_shut_latch: assert property (CLK_EN && !drv_off && s_q.sh_cnt == 2'h2 && sh_evt
      && !chg_a && !chg_b |=> BRIDGE_OFF)
      else $error("third short did not shut bridge");
   a_shut_hold: assert property (BRIDGE_OFF && !(CLK_EN && drv_off) |=> BRIDGE_OFF)
      else $error("bridge shutdown released without disable");
   a_shut_clear: assert property (CLK_EN && drv_off |=> !BRIDGE_OFF && s_q.sh_cnt == 2'h0)
      else $error("disable did not clear shutdown");
   a_short_susp: assert property (CLK_EN && sh_evt && !drv_off |=> CHOP_SUSPEND)
      else $error("short event did not suspend chopper");
   a_ol_set: assert property (CLK_EN && chg_a && !s_q.chop_a |=> s_q.ol_a)
      else $error("open load not set after quiet interval");
   a_ol_keep: assert property (s_q.ol_a && !chg_a
      && CURRENT_A <= (CURRENT_MAX >> sdsi_pkg::OL_CLEAR_SHIFT) |=> s_q.ol_a)
      else $error("open load cleared at low current");
   a_flag_follow: assert property (CLK_EN |=> s_q.sh_a == $past(SHORT_DET_A)
      && s_q.overtemp_warning_flag == $past(OVERTEMP_WARN_IN) && s_q.ot == $past(OVERTEMP_SHUT_IN))
      else $error("status flag did not follow its condition");
   a_stall_pin: assert property (CLK_EN && STALL_DET_IN |=> STALL_TEST_OUTPUT)
      else $error("stall pin not driven high");
   a_resp_load: assert property (CLK_EN && CONFIG_WRITE
      |=> RESPONSE_VALID && DRIVER_STATUS_RESPONSE[7:0] == $past(low_bits))
      else $error("response not loaded with live flags");
   a_freeze_hold: assert property (!CLK_EN |=> $stable(s_q))
      else $error("state changed while clock enable low");
   c_shutdown: cover property (BRIDGE_OFF);
   c_open_load: cover property (s_q.ol_a && s_q.ol_b);
   c_diag_resp: cover property (CLK_EN && CONFIG_WRITE && READ_SELECT == sdsi_pkg::RSEL_DIAG);
   c_step_back: cover property (CLK_EN && step_ifc.step_pulse && step_ifc.step_dir);
endmodule : sdsi_top
`default_nettype wire

// ### tb/sdsi_ctrl_model.sv
// Motion controller model that drives the step and direction pins
`timescale 1ns/1ps
`default_nettype none
module sdsi_ctrl_model (
   input wire logic clk,
   output logic step,
   output logic dir
);
   // Both pins idle low
   initial
   begin
      step = 1'b0;
      dir = 1'b0;
   end
   // One step: direction set early, three clocks high, five low
   task automatic step_once(input logic d);
   begin
      @(negedge clk);
      dir = d;
      repeat (2) @(negedge clk);
      step = 1'b1;
      repeat (3) @(negedge clk);
      step = 1'b0;
      repeat (5) @(negedge clk);
   end
   endtask : step_once
endmodule : sdsi_ctrl_model
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the step input and status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0; // System clock
   logic rst_n, de, cw, en_n, otw, ots, stl, step, dir; // Bench drives
   logic ce; // Clock enable drive
   logic [1:0] sel, pol, chp, sh; // Select, polarity, chop, short
   logic [3:0] res, chopper_off_time; // Step size code, off-time
   logic [9:0] upper; // Foreign upper field
   logic [7:0] cur_a, cur_b, cur_m; // Currents
   logic [19:0] resp; // Response word
   logic [9:0] pos; // Position output
   logic rv, standstill_flag_o, boff, csus, sgt; // Single-bit outputs
   int errors, total_checks, cycles, mpos, i; // Counters, model position
   logic standstill_flag; // Model standstill
   logic [1:0] seen, ol; // Model chop seen, open load
   logic [19:0] exp_q[$]; // Expected responses
   // Clock at 100 MHz
   always #5 clk = ~clk;
   sdsi_ctrl_model ctl_u (.clk(clk), .step(step), .dir(dir));
   sdsi_top #(.STANDSTILL_FLAG_CYCLES(16)) dut_u (.CLOCK(clk), .RSTN(rst_n), .CLK_EN(ce),
      .STEP(step), .DIR(dir), .DOUBLE_EDGE_BIT(de), .MICROSTEP_RES(res),
      .READ_SELECT(sel), .DRIVER_ENABLE_N(en_n), .CHOPPER_OFF_TIME(chopper_off_time),
      .CONFIG_WRITE(cw), .UPPER_FIELD(upper), .POLARITY_A(pol[0]), .POLARITY_B(pol[1]),
      .CHOP_EVENT_A(chp[0]), .CHOP_EVENT_B(chp[1]), .CURRENT_A(cur_a), .CURRENT_B(cur_b),
      .CURRENT_MAX(cur_m), .SHORT_DET_A(sh[0]), .SHORT_DET_B(sh[1]),
      .OVERTEMP_WARN_IN(otw), .OVERTEMP_SHUT_IN(ots), .STALL_DET_IN(stl),
      .DRIVER_STATUS_RESPONSE(resp), .RESPONSE_VALID(rv), .MICROSTEP_POSITION(pos),
      .STANDSTILL_FLAG(standstill_flag_o), .BRIDGE_OFF(boff), .CHOP_SUSPEND(csus),
      .STALL_TEST_OUTPUT(sgt));
   // Verdict and end of run
   task automatic tally_and_finish();
   begin
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   end
   endtask : tally_and_finish
   // Compare and count
   task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
   begin
      total_checks++;
      if (g !== e)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   end
   endtask : chk
   // Single-bit compare
   task automatic chk1(input string nm, input logic e, input logic g);
   begin
      chk(nm, {19'h00000, e}, {19'h00000, g});
   end
   endtask : chk1
   // Expected response from the model state
   function automatic logic [19:0] exp_word();
      logic [1:0] sp;
      sp = (sel == sdsi_pkg::RSEL_DIAG) ? sdsi_pkg::SPARE_ONE : sdsi_pkg::SPARE_ZERO;
      return {(sel == sdsi_pkg::RSEL_MICROSTEP_POSITION) ? mpos[9:0] : upper, sp, standstill_flag, ol[1], ol[0],
         sh[1], sh[0], otw, ots, stl};
   endfunction : exp_word
   // One step through the controller, model follows
   task automatic stp(input logic d);
      int sz;
   begin
      sz = 1 << ((res > 4'h8) ? 8 : res);
      ctl_u.step_once(d);
      mpos = (mpos + (d ? -sz : sz) * (de ? 2 : 1)) & 32'h3FF;
      standstill_flag = 1'b0;
      chk("position", mpos[19:0], {10'h000, pos});
   end
   endtask : stp
   // Configuration write, wait for valid, compare word
   task automatic cfg();
      int n;
   begin
      @(negedge clk);
      exp_q.push_back(exp_word());
      cw = 1'b1;
      @(negedge clk);
      cw = 1'b0;
      n = 0;
      while (rv !== 1'b1 && n < 3)
      begin
         @(negedge clk);
         n++;
      end
      chk("response", exp_q.pop_front(), resp);
   end
   endtask : cfg
   // Chopper event on one coil
   task automatic chop(input int c);
   begin
      @(negedge clk);
      chp[c] = 1'b1;
      seen[c] = 1'b1;
      @(negedge clk);
      chp[c] = 1'b0;
   end
   endtask : chop
   // Polarity change; a quiet interval marks open load
   task automatic flip(input int c);
   begin
      @(negedge clk);
      pol[c] = ~pol[c];
      if (!seen[c])
         ol[c] = 1'b1;
      seen[c] = 1'b0;
      @(negedge clk);
   end
   endtask : flip
   // Short event on coil A, chopper must be suspended
   task automatic shrt();
      int n;
   begin
      @(negedge clk);
      sh[0] = 1'b1;
      n = 0;
      while (csus !== 1'b1 && n < 4)
      begin
         @(negedge clk);
         n++;
      end
      chk1("suspend", 1'b1, csus);
      @(negedge clk);
      sh[0] = 1'b0;
      repeat (2) @(negedge clk);
   end
   endtask : shrt
   // Hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles > 6000)
      begin
         errors++;
         tally_and_finish();
      end
   end
   // Main sequence
   initial
   begin
      {rst_n, de, cw, en_n, otw, ots, stl, sel, pol, chp, sh} = '0;
      {upper, cur_a, cur_b, res, seen, ol, standstill_flag} = '0;
      chopper_off_time = 4'h4;
      ce = 1'b1;
      cur_m = 8'hA0;
      mpos = 0;
      void'($urandom(94));
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      chk("reset word", 20'h00000, resp);
      chk1("reset bridge", 1'b0, boff);
      // Random steps, single then double edge
      for (i = 0; i < 8; i++)
      begin
         de = (i > 3);
         res = 4'($urandom_range(12, 0));
         stp(1'($urandom));
         chk1("standstill", 1'b0, standstill_flag_o);
      end
      // Quiet step input
      repeat (20) @(negedge clk);
      standstill_flag = 1'b1;
      chk1("standstill", 1'b1, standstill_flag_o);
      // Random status in every read-select format
      for (i = 0; i < 8; i++)
      begin
         sel = 2'(i);
         {otw, ots, stl, sh} = 5'($urandom);
         upper = 10'($urandom);
         @(negedge clk);
         cfg();
         chk1("stall pin", stl, sgt);
      end
      sh = 2'h0;
      en_n = 1'b1;
      repeat (2) @(negedge clk);
      chk1("bridge", 1'b0, boff);
      en_n = 1'b0;
      // Open load: coil B quiet, coil A chopping
      sel = sdsi_pkg::RSEL_DIAG;
      chop(0);
      flip(0);
      flip(1);
      cfg();
      cur_b = 8'h0A;
      repeat (2) @(negedge clk);
      cfg();
      chk1("bridge", 1'b0, boff);
      cur_b = 8'h0B;
      repeat (2) @(negedge clk);
      ol[1] = 1'b0;
      cfg();
      cur_b = 8'h00;
      // Short counting up, down and latching
      shrt();
      shrt();
      flip(0);
      shrt();
      chk1("bridge", 1'b0, boff);
      shrt();
      chk1("bridge", 1'b1, boff);
      flip(0);
      chk1("bridge", 1'b1, boff);
      chopper_off_time = 4'h0;
      repeat (2) @(negedge clk);
      chk1("bridge", 1'b0, boff);
      chopper_off_time = 4'h4;
      // Step after standstill clears it
      stp(1'b0);
      chk1("standstill", 1'b0, standstill_flag_o);
      cfg();
      // Clock enable low freezes the stall flag
      stl = ~stl;
      ce = 1'b0;
      repeat (3) @(negedge clk);
      chk1("frozen stall pin", ~stl, sgt);
      ce = 1'b1;
      @(negedge clk);
      chk1("stall pin", stl, sgt);
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
